// ===== design/sxb_pkg.sv
/*
  Shared constants and types for the SMBus slave to expansion-bus bridge.
  Assumes a 40 MHz pclk and an APB register port with 12-bit byte addresses.
*/
package sxb_pkg;
  // Runtime register indices; the byte address is four times the index
  localparam logic [11:0] SXB_IDX_SADDR = 12'h076;
  localparam logic [11:0] SXB_IDX_LPC_ARB = 12'h077;
  localparam logic [11:0] SXB_IDX_STATUS = 12'h078;
  localparam logic [11:0] SXB_A_SADDR = SXB_IDX_SADDR << 2;
  localparam logic [11:0] SXB_A_LPC_ARB = SXB_IDX_LPC_ARB << 2;
  localparam logic [11:0] SXB_A_STATUS = SXB_IDX_STATUS << 2;

  // Internal byte registers reached through command nibble zero
  localparam logic [3:0] SXB_R_COM2 = 4'h0;
  localparam logic [3:0] SXB_R_DDR = 4'h1;
  localparam logic [3:0] SXB_R_ARB = 4'h2;
  localparam logic [3:0] SXB_R_VCC0 = 4'h4;
  localparam logic [3:0] SXB_R_VTR0 = 4'h8;
  localparam logic [3:0] SXB_R_LAST = 4'hb;

  // Command upper nibbles
  localparam logic [3:0] SXB_NIB_INT = 4'h0;
  localparam logic [3:0] SXB_NIB_LCD = 4'h1;
  localparam logic [3:0] SXB_NIB_CS0 = 4'h2;
  localparam logic [3:0] SXB_NIB_CS3 = 4'h5;

  // Arbitration register fields
  localparam int SXB_ARB_REQ = 0;
  localparam int SXB_ARB_GNT = 1;
  localparam int SXB_ARB_MRQ = 2;

  // Select vector positions
  localparam int SXB_SEL_CS1 = 1;
  localparam int SXB_SEL_LCD = 4;

  // Expansion-bus strobe width, rounded up to whole cycles
  localparam int SXB_CLK_PS = 25000;
  localparam int SXB_STROBE_PS = 100000;
  localparam logic [2:0] SXB_STROBE_CYC =
    3'((SXB_STROBE_PS + SXB_CLK_PS - 1) / SXB_CLK_PS);

  localparam logic [1:0] SXB_STRAP_SETTLE = 2'h3;
  localparam logic [3:0] SXB_BITS = 4'h8;
  localparam logic [7:0] SXB_IDLE_BYTE = 8'hff;

  typedef enum logic [2:0] {
    SXB_IDLE = 3'b000,
    SXB_RX = 3'b001,
    SXB_ACK = 3'b010,
    SXB_TX = 3'b011,
    SXB_MACK = 3'b100
  } sxb_state_t;

  typedef enum logic [1:0] {
    SXB_PH_ADDR = 2'b00,
    SXB_PH_CMD = 2'b01,
    SXB_PH_WDATA = 2'b10,
    SXB_PH_RDATA = 2'b11
  } sxb_phase_t;
endpackage

// ===== design/sxb_sync.sv
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module sxb_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sxb_sync_t;

  sxb_sync_t r_q;
  sxb_sync_t r_d;

  always_comb
  begin
    r_d.meta = d;
    r_d.sync = r_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign q = r_q.sync;
endmodule

// ===== design/sxb_arbiter.sv
/*
  Expansion-bus arbiter between the SMBus target and the LPC side.
  Assumes both request inputs come from registers on pclk.
*/
`timescale 1ns/1ps
module sxb_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic smb_req,
  input wire logic smb_mrq,
  input wire logic lpc_req,
  output logic smb_gnt,
  output logic lpc_gnt
);
  typedef struct packed {
    logic smb_gnt;
    logic smb_prev;
    logic lpc_prev;
  } sxb_arb_t;

  sxb_arb_t a_q;
  sxb_arb_t a_d;
  logic lpc_holds;
  logic both_rise;

  always_comb
  begin
    a_d = a_q;
    a_d.smb_prev = smb_req;
    a_d.lpc_prev = lpc_req;
    // LPC holds only once its request has stood for a cycle
    lpc_holds = lpc_req && a_q.lpc_prev;
    // Simultaneous rise keeps the current owner, so no oscillation
    both_rise = smb_req && !a_q.smb_prev && lpc_req && !a_q.lpc_prev;
    if (smb_mrq)
      a_d.smb_gnt = 1'b1;
    else if (a_q.smb_gnt)
      a_d.smb_gnt = smb_req;
    else
      a_d.smb_gnt = smb_req && !lpc_holds && !both_rise;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      a_q <= '0;
    else
      a_q <= a_d;
  end

  assign smb_gnt = a_q.smb_gnt;
  assign lpc_gnt = !a_q.smb_gnt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mrq_wins_a: assert property (smb_mrq |=> smb_gnt)
    else $error("master request did not win the bus");
  lpc_default_a: assert property (!smb_req && !smb_mrq |=> lpc_gnt)
    else $error("bus not returned to LPC when idle");
  smb_hold_a: assert property (smb_gnt && smb_req |=> smb_gnt)
    else $error("SMBus grant taken while still requested");
  lpc_hold_a: assert property (lpc_gnt && lpc_req && $past(lpc_req) && !smb_mrq
    |=> lpc_gnt)
    else $error("LPC grant taken while still requested");
endmodule

// ===== design/sxb_bridge.sv
/*
  SMBus slave-only target bridging Write Byte / Read Byte to internal byte
  registers and to a four-select expansion bus with an LCD strobe.
  Assumes SMBus pins are open drain, sampled here by pclk through two flops;
  LPC-side request comes from the APB runtime register; counters are on pclk.
*/
// Design decision made here: the APB slave port.
// Function
// - Separate slave-only target on shared clock/data pins with its own address.
// - Slave address lives in a software read/write runtime register.
// - Two strap inputs pick one of four boot addresses.
// - Target runs from reset with no software setup.
// - Only Write Byte and Read Byte transactions are handled.
// - After start, address byte first; after its ack, the command byte.
// - Bytes travel MSB first, each followed by receiver's ack bit.
// - Read Byte uses repeated start and ends with host not-acknowledge.
// - Upper nibble selects target; lower nibble drives expansion address lines.
// - Nibble zero reaches internal byte registers zero to eleven.
// - Commands naming undefined internal registers are ignored.
// - Nibble one drives LCD and second select; strobe latches; low bits are LCD address.
// - For expansion accesses odd commands read, even commands write.
// - Nibbles two to five drive selects zero to three.
// - Each arbitration register shows a hardware grant bit.
// - Requests granted first-come; held until holder drops its request.
// - LPC owns the expansion bus after reset.
// - Master request bit gives SMBus the bus regardless of LPC.
`timescale 1ns/1ps
module sxb_bridge #(
  parameter logic [6:0] ADDR_BASE = 7'h2c
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_lo,
  input wire logic addr_strap_hi,
  output logic [3:0] expansion_address_lines,
  output logic expansion_select_zero_n,
  output logic expansion_select_one,
  output logic expansion_select_two_n,
  output logic expansion_select_three_n,
  output logic lcd_select,
  output logic lcd_latch_strobe,
  output logic xbus_rd_n,
  output logic xbus_wr_n,
  input wire logic [7:0] xbus_data_in,
  output logic [7:0] xbus_data_out,
  output logic xbus_data_oe,
  output logic com2_disable,
  output logic [7:0] device_disable,
  output logic lpc_grant,
  input wire logic [31:0] vcc_count,
  input wire logic [31:0] vtr_count
);
  typedef struct packed {
    sxb_pkg::sxb_state_t st;
    sxb_pkg::sxb_phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic sda_oe;
    logic scl_prev;
    logic sda_prev;
    logic active;
    logic [6:0] saddr;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic com2;
    logic [7:0] ddr;
    logic arb_req;
    logic arb_mrq;
    logic lpc_req;
    logic [4:0] xsel;
    logic xrd;
    logic xwr;
    logic [3:0] xaddr;
    logic [7:0] xdout;
    logic xoe;
    logic [2:0] xcnt;
    logic [7:0] rdata;
    logic [31:0] prdata;
  } sxb_bridge_t;

  sxb_bridge_t q;
  sxb_bridge_t d;
  logic [3:0] pins_s;
  logic [7:0] xdin_s;
  logic smb_gnt;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic apb_wr;
  logic apb_hit;

  sxb_sync #(.W(4)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({addr_strap_hi, addr_strap_lo, sda_in, scl_in}),
    .q(pins_s)
  );

  sxb_sync #(.W(8)) u_data_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(xbus_data_in),
    .q(xdin_s)
  );

  sxb_arbiter u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .smb_req(q.arb_req),
    .smb_mrq(q.arb_mrq),
    .lpc_req(q.lpc_req),
    .smb_gnt(smb_gnt),
    .lpc_gnt(lpc_grant)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign rise = scl_s && !q.scl_prev;
  assign fall = !scl_s && q.scl_prev;
  assign start_c = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_c = scl_s && q.scl_prev && !q.sda_prev && sda_s;
  assign apb_wr = psel && penable && pwrite;
  assign apb_hit = (paddr == sxb_pkg::SXB_A_SADDR) || (paddr == sxb_pkg::SXB_A_LPC_ARB)
    || (paddr == sxb_pkg::SXB_A_STATUS);

  function automatic logic [7:0] int_read(input sxb_bridge_t s, input logic [3:0] idx);
    logic [7:0] v;
    v = sxb_pkg::SXB_IDLE_BYTE;
    if (idx == sxb_pkg::SXB_R_COM2)
      v = {7'h00, s.com2};
    else if (idx == sxb_pkg::SXB_R_DDR)
      v = s.ddr;
    else if (idx == sxb_pkg::SXB_R_ARB)
      v = {5'h00, s.arb_mrq, smb_gnt, s.arb_req};
    else if (idx < sxb_pkg::SXB_R_VCC0)
      v = 8'h00;
    else if (idx < sxb_pkg::SXB_R_VTR0)
      v = 8'(vcc_count >> {idx[1:0], 3'h0});
    else if (idx <= sxb_pkg::SXB_R_LAST)
      v = 8'(vtr_count >> {idx[1:0], 3'h0});
    return v;
  endfunction

  // Select vector for an expansion command, zero when the nibble is outside one to five
  function automatic logic [4:0] sel_of(input logic [3:0] nib);
    logic [4:0] v;
    v = 5'h00;
    if (nib == sxb_pkg::SXB_NIB_LCD)
      v = 5'h12;
    else if (nib >= sxb_pkg::SXB_NIB_CS0 && nib <= sxb_pkg::SXB_NIB_CS3)
      v = 5'(5'h01 << (nib - sxb_pkg::SXB_NIB_CS0));
    return v;
  endfunction

  always_comb
  begin
    d = q;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;

    // Straps are caught once, after reset release and synchroniser settle
    if (!q.strap_done)
    begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == sxb_pkg::SXB_STRAP_SETTLE)
      begin
        d.saddr = {ADDR_BASE[6:2], pins_s[3], pins_s[2]};
        d.strap_done = 1'b1;
      end
    end

    // APB writes
    if (apb_wr && paddr == sxb_pkg::SXB_A_SADDR && q.strap_done)
      d.saddr = pwdata[6:0];
    if (apb_wr && paddr == sxb_pkg::SXB_A_LPC_ARB)
      d.lpc_req = pwdata[sxb_pkg::SXB_ARB_REQ];
    // Read data is latched in the setup cycle so it stands for the access phase
    if (psel && !penable)
    begin
      d.prdata = 32'h0;
      if (paddr == sxb_pkg::SXB_A_SADDR)
        d.prdata = {25'h0, q.saddr};
      else if (paddr == sxb_pkg::SXB_A_LPC_ARB)
        d.prdata = {30'h0, lpc_grant, q.lpc_req};
      else if (paddr == sxb_pkg::SXB_A_STATUS)
        d.prdata = {22'h0, smb_gnt, q.active, q.cmd};
    end

    // Expansion strobe timing; grant loss cuts the cycle short
    if (q.xcnt != 3'h0)
    begin
      d.xcnt = q.xcnt - 3'h1;
      if (q.xcnt == 3'h1 || !smb_gnt)
      begin
        if (q.xrd)
          d.rdata = smb_gnt ? xdin_s : sxb_pkg::SXB_IDLE_BYTE;
        d.xsel = 5'h00;
        d.xrd = 1'b0;
        d.xwr = 1'b0;
        d.xoe = 1'b0;
        d.xcnt = 3'h0;
      end
    end

    if (stop_c)
    begin
      d.st = sxb_pkg::SXB_IDLE;
      d.sda_oe = 1'b0;
      d.active = 1'b0;
    end
    else if (start_c)
    begin
      // Also a repeated start inside Read Byte
      d.st = sxb_pkg::SXB_RX;
      d.ph = sxb_pkg::SXB_PH_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.active = 1'b1;
    end
    else
    begin
      unique case (q.st)
        sxb_pkg::SXB_IDLE:
        begin
          d.sda_oe = 1'b0;
        end
        sxb_pkg::SXB_RX:
        begin
          if (rise && q.cnt < sxb_pkg::SXB_BITS)
          begin
            d.sh = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end
          else if (fall && q.cnt == sxb_pkg::SXB_BITS)
          begin
            d.st = sxb_pkg::SXB_IDLE;
            unique case (q.ph)
              sxb_pkg::SXB_PH_ADDR:
              begin
                if (q.sh[7:1] == q.saddr)
                begin
                  d.st = sxb_pkg::SXB_ACK;
                  d.sda_oe = 1'b1;
                  if (q.sh[0])
                  begin
                    // Read phase: fetch now so the byte is ready at ack end
                    d.ph = sxb_pkg::SXB_PH_RDATA;
                    d.rdata = sxb_pkg::SXB_IDLE_BYTE;
                    if (q.cmd[7:4] == sxb_pkg::SXB_NIB_INT)
                      d.rdata = int_read(q, q.cmd[3:0]);
                    else if (sel_of(q.cmd[7:4]) != 5'h00 && smb_gnt && q.cmd[0])
                    begin
                      d.xsel = sel_of(q.cmd[7:4]);
                      d.xaddr = q.cmd[3:0];
                      d.xrd = 1'b1;
                      d.xcnt = sxb_pkg::SXB_STROBE_CYC;
                    end
                  end
                  else
                    d.ph = sxb_pkg::SXB_PH_CMD;
                end
              end
              sxb_pkg::SXB_PH_CMD:
              begin
                // Cleared count tells the ack state a command, not data, was taken
                d.cnt = 4'h0;
                d.cmd = q.sh;
                d.ph = sxb_pkg::SXB_PH_WDATA;
                d.st = sxb_pkg::SXB_ACK;
                d.sda_oe = 1'b1;
              end
              sxb_pkg::SXB_PH_WDATA:
              begin
                if (q.cmd[7:4] == sxb_pkg::SXB_NIB_INT && q.cmd[3:0] <= sxb_pkg::SXB_R_LAST)
                begin
                  d.st = sxb_pkg::SXB_ACK;
                  d.sda_oe = 1'b1;
                  if (q.cmd[3:0] == sxb_pkg::SXB_R_COM2)
                    d.com2 = q.sh[0];
                  else if (q.cmd[3:0] == sxb_pkg::SXB_R_DDR)
                    d.ddr = q.sh;
                  else if (q.cmd[3:0] == sxb_pkg::SXB_R_ARB)
                  begin
                    d.arb_req = q.sh[sxb_pkg::SXB_ARB_REQ];
                    d.arb_mrq = q.sh[sxb_pkg::SXB_ARB_MRQ];
                  end
                end
                else if (sel_of(q.cmd[7:4]) != 5'h00 && smb_gnt && !q.cmd[0])
                begin
                  d.st = sxb_pkg::SXB_ACK;
                  d.sda_oe = 1'b1;
                  d.xsel = sel_of(q.cmd[7:4]);
                  d.xaddr = q.cmd[3:0];
                  d.xdout = q.sh;
                  d.xoe = 1'b1;
                  d.xwr = 1'b1;
                  d.xcnt = sxb_pkg::SXB_STROBE_CYC;
                end
                // Anything else is not acknowledged and leaves no effect
              end
              sxb_pkg::SXB_PH_RDATA:
              begin
                d.st = sxb_pkg::SXB_IDLE;
              end
            endcase
          end
        end
        sxb_pkg::SXB_ACK:
        begin
          if (fall)
          begin
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
            if (q.ph == sxb_pkg::SXB_PH_RDATA)
            begin
              d.st = sxb_pkg::SXB_TX;
              d.sh = q.rdata;
              d.sda_oe = !q.rdata[7];
              d.cnt = 4'h1;
            end
            else if (q.ph == sxb_pkg::SXB_PH_WDATA && q.cnt == sxb_pkg::SXB_BITS)
              d.st = sxb_pkg::SXB_IDLE;
            else
              d.st = sxb_pkg::SXB_RX;
          end
        end
        sxb_pkg::SXB_TX:
        begin
          if (fall)
          begin
            if (q.cnt == sxb_pkg::SXB_BITS)
            begin
              d.sda_oe = 1'b0;
              d.st = sxb_pkg::SXB_MACK;
            end
            else
            begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        sxb_pkg::SXB_MACK:
        begin
          // Host answers with not-acknowledge; either way the byte is done
          if (rise)
            d.st = sxb_pkg::SXB_IDLE;
        end
        default:
        begin
          d.st = sxb_pkg::SXB_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.saddr <= ADDR_BASE;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign expansion_address_lines = q.xaddr;
  assign expansion_select_zero_n = !q.xsel[0];
  assign expansion_select_one = q.xsel[sxb_pkg::SXB_SEL_CS1];
  assign expansion_select_two_n = !q.xsel[2];
  assign expansion_select_three_n = !q.xsel[3];
  assign lcd_select = q.xsel[sxb_pkg::SXB_SEL_LCD];
  assign lcd_latch_strobe = q.xsel[sxb_pkg::SXB_SEL_LCD] && (q.xrd || q.xwr);
  assign xbus_rd_n = !q.xrd;
  assign xbus_wr_n = !q.xwr;
  assign xbus_data_out = q.xdout;
  assign xbus_data_oe = q.xoe;
  assign com2_disable = q.com2;
  assign device_disable = q.ddr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Grant loss may cut the strobe, so only a strobe that kept the grant is timed
  sequence strobe_open_s;
    $rose(q.xrd || q.xwr) && smb_gnt ##1 smb_gnt[*2];
  endsequence

  sequence strobe_run_s;
    (q.xrd || q.xwr) ##1 !(q.xrd || q.xwr);
  endsequence

  strobe_width_a: assert property (strobe_open_s |=> strobe_run_s)
    else $error("expansion strobe width wrong");
  sel_needs_grant_a: assert property (q.xsel != 5'h00 |-> $past(smb_gnt))
    else $error("select driven without SMBus grant");
  addr_lines_a: assert property (q.xsel != 5'h00 |-> q.xaddr == q.cmd[3:0])
    else $error("address lines differ from command low nibble");
  lcd_pair_a: assert property (lcd_select |-> expansion_select_one)
    else $error("LCD select without second select");
  dir_read_a: assert property ($rose(q.xrd) |-> q.cmd[0])
    else $error("expansion read from even command");
  dir_write_a: assert property ($rose(q.xwr) |-> !q.cmd[0] && q.xdout == $past(q.sh))
    else $error("expansion write wrong direction or data");
  strap_load_a: assert property ($rose(q.strap_done)
    |-> q.saddr[1:0] == $past(pins_s[3:2]))
    else $error("boot address not taken from straps");
  saddr_write_a: assert property (apb_wr && paddr == sxb_pkg::SXB_A_SADDR
    && q.strap_done |=> q.saddr == $past(pwdata[6:0]))
    else $error("slave address register not written");
  ignore_undef_a: assert property (q.st == sxb_pkg::SXB_RX && fall
    && q.cnt == sxb_pkg::SXB_BITS && q.ph == sxb_pkg::SXB_PH_WDATA
    && q.cmd[7:4] == sxb_pkg::SXB_NIB_INT && q.cmd[3:0] > sxb_pkg::SXB_R_LAST
    |=> !q.sda_oe && $stable(q.ddr) && $stable(q.com2))
    else $error("undefined internal register not ignored");
endmodule

// ===== testbench/sxb_host.sv
/*
  SMBus host model: drives the link clock and an open-drain data pull.
  Assumes the bench resolves the pulled-up data wire from all pulls.
*/
`timescale 1ns/1ps
module sxb_host (
  input wire logic sda,
  output logic scl,
  output logic pull
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // Clock rests high between frames; data bits move only while it is low, start and stop move it while high
  task automatic bitw(input logic b);
    pull = !b;
    #60 scl = 1'b1;
    #100 scl = 1'b0;
    #40;
  endtask

  task automatic bitr(output logic b);
    pull = 1'b0;
    #60 scl = 1'b1;
    #50 b = sda;
    #50 scl = 1'b0;
    #40;
  endtask

  // Long lead-in so an ack still held by the target has gone
  task automatic start;
    // Small offset keeps every pin change off the pclk sampling edges
    #2;
    pull = 1'b0;
    #100 scl = 1'b1;
    #100 pull = 1'b1;
    #100 scl = 1'b0;
    #40;
  endtask

  task automatic stop;
    pull = 1'b1;
    #60 scl = 1'b1;
    #100 pull = 1'b0;
    #100;
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bitw(v[i]);
    bitr(b);
    ack = !b;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic [2:0] ak);
    ak = 3'b000;
    start;
    wbyte({a, 1'b0}, ak[2]);
    if (ak[2])
    begin
      wbyte(c, ak[1]);
      wbyte(d, ak[0]);
    end
    stop;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                    output logic [2:0] ak);
    logic b;
    ak = 3'b000;
    d = 8'h00;
    start;
    wbyte({a, 1'b0}, ak[2]);
    if (ak[2])
    begin
      wbyte(c, ak[1]);
      start;
      wbyte({a, 1'b1}, ak[0]);
      for (int i = 7; i >= 0; i--)
      begin
        bitr(b);
        d[i] = b;
      end
      bitw(1'b1);
    end
    stop;
  endtask
endmodule

// ===== testbench/tb_smbus_slave_xbus_bridge.sv
/*
  Self-checking bench for the SMBus slave expansion-bus bridge.
  Assumes sxb_host for the link and the bridge's zero-wait APB port.
*/
`timescale 1ns/1ps
module tb_smbus_slave_xbus_bridge;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, vcc_count, vtr_count, seed, ra;
  logic scl, pull, sda_oe, sda_out, sda, xbus_rd_n, xbus_wr_n, xbus_data_oe;
  logic lcd_select, lcd_latch_strobe, com2_disable, lpc_grant;
  logic expansion_select_zero_n, expansion_select_one;
  logic expansion_select_two_n, expansion_select_three_n;
  logic [3:0] expansion_address_lines, xa_seen;
  logic [7:0] xbus_data_in, xbus_data_out, xd_seen, device_disable;
  logic [5:0] sel_seen;
  logic [6:0] sa;
  int n_fail, checks, cyc;

  assign sda = !(pull | (sda_oe & !sda_out));

  sxb_bridge i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .addr_strap_lo(1'b0), .addr_strap_hi(1'b1), .expansion_address_lines,
    .expansion_select_zero_n, .expansion_select_one, .expansion_select_two_n,
    .expansion_select_three_n, .lcd_select, .lcd_latch_strobe, .xbus_rd_n,
    .xbus_wr_n, .xbus_data_in, .xbus_data_out, .xbus_data_oe, .com2_disable,
    .device_disable, .lpc_grant, .vcc_count, .vtr_count);

  sxb_host i_host (.sda(sda), .scl(scl), .pull(pull));

  initial pclk = 1'b0;
  always #12.5 pclk = !pclk;

  always @(posedge pclk)
    if (!xbus_wr_n || !xbus_rd_n)
    begin
      sel_seen <= {lcd_latch_strobe, lcd_select, !expansion_select_three_n,
                   !expansion_select_two_n, expansion_select_one, !expansion_select_zero_n};
      xa_seen <= expansion_address_lines;
      xd_seen <= xbus_data_out;
    end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Bits: strobe, lcd, sel3, sel2, sel1, sel0
  function automatic logic [5:0] exp_sel(input logic [3:0] n);
    return (n == 4'h1) ? 6'h32 : 6'h01 << (n - 4'h2);
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    ra = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sw(input logic [7:0] c, d, input logic [2:0] ea);
    logic [2:0] ak;
    i_host.wr(sa, c, d, ak);
    repeat (4) @(posedge pclk);
    chk(32'(ak), 32'(ea));
  endtask

  task automatic sr(input logic [7:0] c, e);
    logic [7:0] v;
    logic [2:0] ak;
    i_host.rd(sa, c, v, ak);
    repeat (4) @(posedge pclk);
    chk(32'(ak), 32'h7);
    chk(32'(v), 32'(e));
  endtask

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h71ec;
    vcc_count = lfsr(seed);
    vtr_count = lfsr(vcc_count);
    xbus_data_in = 8'h00;
    sa = 7'h2e;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(lpc_grant), 32'h1);
    chk(32'(xbus_wr_n & xbus_rd_n & expansion_select_zero_n), 32'h1);
    seed = lfsr(vtr_count);
    sw(8'h01, seed[7:0], 3'b111);
    chk(32'(device_disable), 32'(seed[7:0]));
    sr(8'h01, seed[7:0]);
    sw(8'h00, 8'h01, 3'b111);
    chk(32'(com2_disable), 32'h1);
    for (int r = 4; r < 12; r++)
      sr(8'(r), 8'({vtr_count, vcc_count} >> (8 * (r - 4))));
    sr(8'h03, 8'h00);
    sw(8'h0c, 8'h5a, 3'b110);
    chk(32'(device_disable), 32'(seed[7:0]));
    sr(8'h0f, 8'hff);
    apb(1'b0, sxb_pkg::SXB_A_SADDR, 32'h0);
    chk(32'(ra[6:0]), 32'h2e);
    $display("test internal done");
    sa = 7'h2f;
    sw(8'h01, 8'h00, 3'b000);
    sa = 7'h2e;
    sel_seen = '0;
    sw(8'h20, 8'h11, 3'b110);
    chk(32'(sel_seen), 32'h0);
    sw(8'h02, 8'h01, 3'b111);
    chk(32'(lpc_grant), 32'h0);
    sr(8'h02, 8'h03);
    apb(1'b0, sxb_pkg::SXB_A_STATUS, 32'h0);
    chk(32'(ra[9:0]), 32'h202);
    for (int n = 1; n < 6; n++)
    begin
      seed = lfsr(seed);
      sel_seen = '0;
      xbus_data_in <= seed[23:16];
      sw({4'(n), seed[3:1], 1'b0}, seed[15:8], 3'b111);
      chk(32'(sel_seen), 32'(exp_sel(4'(n))));
      chk(32'({xa_seen, xd_seen}), 32'({seed[3:1], 1'b0, seed[15:8]}));
      sr({4'(n), seed[7:5], 1'b1}, seed[23:16]);
      chk(32'(xa_seen), 32'({seed[7:5], 1'b1}));
    end
    $display("test expansion done");
    apb(1'b1, sxb_pkg::SXB_A_LPC_ARB, 32'h1);
    chk(32'(lpc_grant), 32'h0);
    sw(8'h02, 8'h00, 3'b111);
    chk(32'(lpc_grant), 32'h1);
    sw(8'h02, 8'h01, 3'b111);
    chk(32'(lpc_grant), 32'h1);
    sel_seen = '0;
    sw(8'h30, 8'h00, 3'b110);
    chk(32'(sel_seen), 32'h0);
    sw(8'h02, 8'h05, 3'b111);
    chk(32'(lpc_grant), 32'h0);
    apb(1'b0, sxb_pkg::SXB_A_LPC_ARB, 32'h0);
    chk(32'(ra[1:0]), 32'h1);
    $display("test arbitration done");
    apb(1'b1, sxb_pkg::SXB_A_SADDR, 32'h51);
    apb(1'b0, sxb_pkg::SXB_A_SADDR, 32'h0);
    chk(32'(ra[6:0]), 32'h51);
    sw(8'h01, 8'h00, 3'b000);
    sa = 7'h51;
    sw(8'h01, 8'h3c, 3'b111);
    apb(1'b1, 12'h100, 32'h0);
    chk(32'(re), 32'h1);
    $display("test address done");
    test_done();
  end
endmodule
